// [rtl/dsmm_pkg.sv]
// constants and types for the dual supply mode manager
package dsmm_pkg;

    // register port widths
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [3:0] PCR_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h1;

    // power_control_reg field positions
    localparam int unsigned RISE_FLAG_BIT = 7;
    localparam int unsigned FALL_FLAG_BIT = 6;
    localparam int unsigned CABLE_FLAG_BIT = 5;
    localparam int unsigned IRQ_EN_BIT = 4;
    localparam int unsigned LEVEL_LSB = 2;
    localparam int unsigned DET_OFF_BIT = 1;
    localparam int unsigned REG_ON_BIT = 0;

    // status register field positions
    localparam int unsigned STAT_USB_BIT = 0;
    localparam int unsigned STAT_RESET_BIT = 1;
    localparam int unsigned STAT_PLL_BIT = 2;
    localparam int unsigned STAT_MEDIA_BIT = 3;

    // reset values
    localparam logic [7:0] PCR_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // regulator_level_sel encodings
    localparam logic [1:0] LEVEL_3V5 = 2'h0;
    localparam logic [1:0] LEVEL_3V4 = 2'h1;
    localparam logic [1:0] LEVEL_3V3 = 2'h2;
    localparam logic [1:0] LEVEL_2V8 = 2'h3;

    // reset phase lengths in clock cycles
    localparam logic [9:0] SA_RESET_CYCLES = 10'h200;
    localparam logic [9:0] USB_RESET_CYCLES = 10'h100;

    // clock rate limits per mode, in MHz
    localparam logic [3:0] SA_CORE_MAX_MHZ = 4'h6;
    localparam logic [3:0] USB_CORE_MAX_MHZ = 4'h8;
    localparam logic [4:0] SA_COPROC_MHZ = 5'h06;
    localparam logic [4:0] USB_COPROC_MHZ = 5'h18;
    localparam logic [5:0] PLL_MHZ = 6'h30;

    typedef enum {
        MODE_RESET,
        MODE_STANDALONE,
        MODE_USB
    } dsmm_state_t;

    typedef struct packed {
        logic riseFlag;
        logic fallFlag;
        logic cableDetectFlag;
        logic cableDetectIrqEn;
        logic [1:0] regulatorLevelSel;
        logic detectorOff;
        logic regulatorOn;
    } dsmm_pcr_t;

    typedef struct packed {
        logic pllOn;
        logic pllClkSel;
        logic usbIfOn;
        logic [5:0] pllMhz;
        logic [3:0] coreMaxMhz;
        logic [4:0] coprocMhz;
    } dsmm_clkcfg_t;

endpackage

// [rtl/dsmm_mode_manager.sv]
// dual supply mode manager: cable detect, mode select, supply switch and regulator control
// Contract
// - stand-alone: pll off, usb off, 6/6 MHz
// - usb: pll 48 MHz, usb on, 8/24 MHz
// - stand-alone and stand-alone-bound reset: switch undriven
// - usb and usb-bound reset: switch driven low
// - rise above threshold with enable: interrupt
// - fall below threshold in usb: interrupt
// - mode switch reset puts ports high impedance
// - reset to stand-alone stops pll, crystal clock
// - four software selectable regulator output levels
// - media rail absent: media ios held low
// - level select 00/01/10/11 = 3.5/3.4/3.3/2.8
// - flag edges interrupt when enabled, wake halt
// - regulator_on bit 0 powers regulator
module dsmm_mode_manager (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [dsmm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [dsmm_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [dsmm_pkg::DATA_W-1:0] regRdata,
    input wire logic busAboveRise,
    input wire logic busAboveFall,
    input wire logic pllLock,
    input wire logic swResetReq,
    input wire logic mediaRailPresent,
    output logic cableIrq,
    output logic wakeReq,
    output logic supplySwitchOut,
    output logic supplySwitchOe_n,
    output dsmm_pkg::dsmm_clkcfg_t clkCfg,
    output logic ioHighZ,
    output logic mediaIoTieLow,
    output logic regulatorOn,
    output logic [1:0] regulatorLevelSel,
    output logic coreReset_n,
    output logic usbModeActive
);

    dsmm_pkg::dsmm_state_t state_q;
    dsmm_pkg::dsmm_state_t state_d;
    dsmm_pkg::dsmm_pcr_t pcr_q;
    logic [9:0] rstCount_q;
    logic [9:0] rstCount_d;
    logic targetUsb_q;
    logic targetUsb_d;
    logic lockSeen_q;
    logic cableFlag_d;
    logic riseFlag_d;
    logic fallFlag_d;
    logic flagEdge;
    logic fallInUsb;
    logic resetDone;
    logic pcrWrite;
    logic [dsmm_pkg::DATA_W-1:0] regRdata_q;
    logic cableIrq_q;
    logic wakeReq_q;
    logic supplySwitchOut_q;
    logic supplySwitchOe_n_q;
    dsmm_pkg::dsmm_clkcfg_t clkCfg_q;
    logic ioHighZ_q;
    logic mediaIoTieLow_q;
    logic regulatorOn_q;
    logic [1:0] regulatorLevelSel_q;
    logic coreReset_n_q;
    logic usbModeActive_q;

    // detector comparators; forced high while the detector is powered off
    assign riseFlag_d = busAboveRise | pcr_q.detectorOff;
    assign fallFlag_d = busAboveFall | pcr_q.detectorOff;

    // cable flag with hysteresis: set above rise, cleared below fall
    always_comb begin
        cableFlag_d = pcr_q.cableDetectFlag;
        if (pcr_q.detectorOff) begin
            cableFlag_d = 1'b1;
        end else if (busAboveRise) begin
            cableFlag_d = 1'b1;
        end else if (!busAboveFall) begin
            cableFlag_d = 1'b0;
        end
    end

    assign flagEdge = cableFlag_d != pcr_q.cableDetectFlag;
    assign fallInUsb = pcr_q.cableDetectFlag && !cableFlag_d && (state_q == dsmm_pkg::MODE_USB);
    assign pcrWrite = regWrite && (regAddr == dsmm_pkg::PCR_OFS);

    // reset phase ends after the count; usb waits for pll lock first
    assign resetDone = (state_q == dsmm_pkg::MODE_RESET) && (rstCount_q == 10'h000)
        && (!targetUsb_q || lockSeen_q);

    // power_control_reg: software fields and hardware flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcr_q <= dsmm_pkg::PCR_RESET;
        end else begin
            pcr_q.riseFlag <= riseFlag_d;
            pcr_q.fallFlag <= fallFlag_d;
            pcr_q.cableDetectFlag <= cableFlag_d;
            if (pcrWrite) begin
                pcr_q.cableDetectIrqEn <= regWdata[dsmm_pkg::IRQ_EN_BIT];
                pcr_q.regulatorLevelSel <= regWdata[dsmm_pkg::LEVEL_LSB +: 2];
                pcr_q.detectorOff <= regWdata[dsmm_pkg::DET_OFF_BIT];
                pcr_q.regulatorOn <= regWdata[dsmm_pkg::REG_ON_BIT];
            end
        end
    end

    // mode sequencing through the reset phase
    always_comb begin
        state_d = state_q;
        rstCount_d = rstCount_q;
        targetUsb_d = targetUsb_q;
        case (state_q)
            dsmm_pkg::MODE_RESET: begin
                if (rstCount_q != 10'h000) begin
                    if (!targetUsb_q || lockSeen_q) begin
                        rstCount_d = rstCount_q - 10'h001;
                    end
                end else if (resetDone) begin
                    // mode taken from flag at reset end
                    if (pcr_q.cableDetectFlag) begin
                        state_d = dsmm_pkg::MODE_USB;
                    end else begin
                        state_d = dsmm_pkg::MODE_STANDALONE;
                    end
                end
            end
            dsmm_pkg::MODE_STANDALONE, dsmm_pkg::MODE_USB: begin
                if (swResetReq) begin
                    state_d = dsmm_pkg::MODE_RESET;
                    targetUsb_d = pcr_q.cableDetectFlag;
                    rstCount_d = pcr_q.cableDetectFlag ? dsmm_pkg::USB_RESET_CYCLES
                        : dsmm_pkg::SA_RESET_CYCLES;
                end
            end
            default: begin
                state_d = dsmm_pkg::MODE_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= dsmm_pkg::MODE_RESET;
            rstCount_q <= dsmm_pkg::SA_RESET_CYCLES;
            targetUsb_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rstCount_q <= rstCount_d;
            targetUsb_q <= targetUsb_d;
        end
    end

    // pll lock seen during a usb-bound reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockSeen_q <= 1'b0;
        end else if (state_q != dsmm_pkg::MODE_RESET) begin
            lockSeen_q <= 1'b0;
        end else if (targetUsb_q && pllLock) begin
            lockSeen_q <= 1'b1;
        end
    end

    // cable interrupt request, one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cableIrq_q <= 1'b0;
        end else begin
            cableIrq_q <= (flagEdge && pcr_q.cableDetectIrqEn) || fallInUsb;
        end
    end

    // halt wake, same timing as the interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeReq_q <= 1'b0;
        end else begin
            wakeReq_q <= (flagEdge && pcr_q.cableDetectIrqEn) || fallInUsb;
        end
    end

    // switch pin value: only ever drives low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supplySwitchOut_q <= 1'b0;
        end else begin
            supplySwitchOut_q <= 1'b0;
        end
    end

    // supply switch enable: driven for usb, released otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supplySwitchOe_n_q <= 1'b1;
        end else begin
            // drive low in usb and usb reset
            if (state_d == dsmm_pkg::MODE_USB
                || (state_d == dsmm_pkg::MODE_RESET && targetUsb_d)) begin
                supplySwitchOe_n_q <= 1'b0;
            end else begin
                supplySwitchOe_n_q <= 1'b1;
            end
        end
    end

    // clock configuration per mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkCfg_q.pllOn <= 1'b0;
            clkCfg_q.pllClkSel <= 1'b0;
            clkCfg_q.usbIfOn <= 1'b0;
            clkCfg_q.pllMhz <= dsmm_pkg::PLL_MHZ;
            clkCfg_q.coreMaxMhz <= dsmm_pkg::SA_CORE_MAX_MHZ;
            clkCfg_q.coprocMhz <= dsmm_pkg::SA_COPROC_MHZ;
        end else begin
            clkCfg_q.pllMhz <= dsmm_pkg::PLL_MHZ;
            if (state_d == dsmm_pkg::MODE_USB) begin
                clkCfg_q.pllOn <= 1'b1;
                clkCfg_q.pllClkSel <= 1'b1;
                clkCfg_q.usbIfOn <= 1'b1;
                clkCfg_q.coreMaxMhz <= dsmm_pkg::USB_CORE_MAX_MHZ;
                clkCfg_q.coprocMhz <= dsmm_pkg::USB_COPROC_MHZ;
            end else if (state_d == dsmm_pkg::MODE_RESET && targetUsb_d) begin
                // pll starts so lock can end the reset
                clkCfg_q.pllOn <= 1'b1;
                clkCfg_q.pllClkSel <= 1'b0;
                clkCfg_q.usbIfOn <= 1'b0;
                clkCfg_q.coreMaxMhz <= dsmm_pkg::SA_CORE_MAX_MHZ;
                clkCfg_q.coprocMhz <= dsmm_pkg::SA_COPROC_MHZ;
            end else begin
                clkCfg_q.pllOn <= 1'b0;
                clkCfg_q.pllClkSel <= 1'b0;
                clkCfg_q.usbIfOn <= 1'b0;
                clkCfg_q.coreMaxMhz <= dsmm_pkg::SA_CORE_MAX_MHZ;
                clkCfg_q.coprocMhz <= dsmm_pkg::SA_COPROC_MHZ;
            end
        end
    end

    // port release during the reset phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ioHighZ_q <= 1'b1;
        end else begin
            ioHighZ_q <= state_d == dsmm_pkg::MODE_RESET;
        end
    end

    // core held until the reset phase ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coreReset_n_q <= 1'b0;
        end else begin
            coreReset_n_q <= state_d != dsmm_pkg::MODE_RESET;
        end
    end

    // running mode indication
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usbModeActive_q <= 1'b0;
        end else begin
            usbModeActive_q <= state_d == dsmm_pkg::MODE_USB;
        end
    end

    // regulator controls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulatorOn_q <= 1'b0;
            regulatorLevelSel_q <= dsmm_pkg::LEVEL_3V5;
        end else begin
            regulatorOn_q <= pcr_q.regulatorOn;
            regulatorLevelSel_q <= pcr_q.regulatorLevelSel;
        end
    end

    // media rail ios
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mediaIoTieLow_q <= 1'b1;
        end else begin
            mediaIoTieLow_q <= !mediaRailPresent;
        end
    end

    // register read data, valid the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= dsmm_pkg::RDATA_RESET;
        end else if (regRead) begin
            regRdata_q <= dsmm_pkg::RDATA_RESET;
            if (regAddr == dsmm_pkg::PCR_OFS) begin
                regRdata_q <= pcr_q;
            end else if (regAddr == dsmm_pkg::STATUS_OFS) begin
                regRdata_q[dsmm_pkg::STAT_USB_BIT] <= state_q == dsmm_pkg::MODE_USB;
                regRdata_q[dsmm_pkg::STAT_RESET_BIT] <= state_q == dsmm_pkg::MODE_RESET;
                regRdata_q[dsmm_pkg::STAT_PLL_BIT] <= clkCfg_q.pllOn;
                regRdata_q[dsmm_pkg::STAT_MEDIA_BIT] <= mediaRailPresent;
            end
        end else begin
            regRdata_q <= dsmm_pkg::RDATA_RESET;
        end
    end

    // ports straight from their flip-flops
    assign regRdata = regRdata_q;
    assign cableIrq = cableIrq_q;
    assign wakeReq = wakeReq_q;
    assign supplySwitchOut = supplySwitchOut_q;
    assign supplySwitchOe_n = supplySwitchOe_n_q;
    assign clkCfg = clkCfg_q;
    assign ioHighZ = ioHighZ_q;
    assign mediaIoTieLow = mediaIoTieLow_q;
    assign regulatorOn = regulatorOn_q;
    assign regulatorLevelSel = regulatorLevelSel_q;
    assign coreReset_n = coreReset_n_q;
    assign usbModeActive = usbModeActive_q;

endmodule

// [tb/dsmm_mode_monitor.sv]
// checker for mode, clock setup, switch pin, regulator and cable interrupt
module dsmm_mode_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic busAboveRise,
    input wire logic busAboveFall,
    input wire logic swResetReq,
    input wire logic mediaRailPresent,
    input wire logic cableIrq,
    input wire logic wakeReq,
    input wire logic supplySwitchOut,
    input wire logic supplySwitchOe_n,
    input wire dsmm_pkg::dsmm_clkcfg_t clkCfg,
    input wire logic ioHighZ,
    input wire logic mediaIoTieLow,
    input wire logic regulatorOn,
    input wire logic [1:0] regulatorLevelSel,
    input wire logic coreReset_n,
    input wire logic usbModeActive
);
    logic cableFlag_q;
    logic [7:0] pcrCopy_q;
    logic runSa;
    logic pcrWr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign runSa = coreReset_n && !usbModeActive;
    assign pcrWr = regWrite && regAddr == dsmm_pkg::PCR_OFS;
    // mirror of the cable flag, set above rise, cleared below fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cableFlag_q <= 1'b0;
        end else if (busAboveRise) begin
            cableFlag_q <= 1'b1;
        end else if (!busAboveFall) begin
            cableFlag_q <= 1'b0;
        end
    end
    // last written control byte, forgotten over a reset phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n || !coreReset_n) begin
            pcrCopy_q <= 8'h00;
        end else if (pcrWr) begin
            pcrCopy_q <= regWdata;
        end
    end
    sa_clocks_a: assert property (runSa [*2] |-> !clkCfg.pllOn && !clkCfg.usbIfOn &&
        clkCfg.coreMaxMhz == 4'h6 && clkCfg.coprocMhz == 5'h06) else $error("stand-alone clock setup wrong");
    usb_clocks_a: assert property (usbModeActive [*2] |-> clkCfg.pllOn && clkCfg.usbIfOn &&
        clkCfg.pllMhz == 6'h30 && clkCfg.coreMaxMhz == 4'h8 && clkCfg.coprocMhz == 5'h18) else $error("usb clock setup wrong");
    sa_switch_float_a: assert property (runSa [*2] |-> supplySwitchOe_n) else $error("switch driven in stand-alone");
    usb_switch_low_a: assert property (usbModeActive |-> !supplySwitchOe_n && !supplySwitchOut)
        else $error("switch not driven low in usb mode");
    rise_irq_a: assert property (coreReset_n && pcrCopy_q[4] && !cableFlag_q && busAboveRise |-> ##[1:2] cableIrq)
        else $error("no interrupt on plug");
    fall_irq_a: assert property (usbModeActive && cableFlag_q && !busAboveRise && !busAboveFall |-> ##[1:2] cableIrq)
        else $error("no interrupt on unplug");
    wake_irq_a: assert property (wakeReq == cableIrq) else $error("wake differs from interrupt");
    usb_reset_a: assert property (coreReset_n && swResetReq && cableFlag_q |=>
        ioHighZ && !coreReset_n && !supplySwitchOe_n) else $error("usb-bound reset wrong");
    sa_reset_a: assert property (coreReset_n && swResetReq && !cableFlag_q |=>
        ioHighZ && !clkCfg.pllOn && supplySwitchOe_n) else $error("stand-alone reset wrong");
    level_copy_a: assert property (pcrWr |-> ##2 regulatorLevelSel == pcrCopy_q[3:2] &&
        regulatorOn == pcrCopy_q[0]) else $error("regulator outputs do not follow write");
    media_tie_a: assert property (!mediaRailPresent [*2] |-> mediaIoTieLow) else $error("media ios not tied");
    mode_hold_a: assert property (coreReset_n && $past(coreReset_n) |-> $stable(usbModeActive))
        else $error("mode changed while running");
    cover property (cableIrq);
    cover property ($rose(usbModeActive));
    cover property (coreReset_n && swResetReq);
endmodule

// [tb/dsmm_supply_model.sv]
// far side: bus supply rail thresholds, external supply switch, pll lock
module dsmm_supply_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] railLevel,
    input wire logic pllOn,
    input wire logic supplySwitchOut,
    input wire logic supplySwitchOe_n,
    output logic busAboveRise,
    output logic busAboveFall,
    output logic pllLock,
    output logic switchOn
);
    logic [3:0] lockCnt_q;
    // rail level 2 above rise threshold, 1 between, 0 below fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busAboveRise <= 1'b0;
            busAboveFall <= 1'b0;
            lockCnt_q <= 4'h0;
        end else begin
            busAboveRise <= railLevel == 2'h2;
            busAboveFall <= railLevel != 2'h0;
            lockCnt_q <= !pllOn ? 4'h0 : (lockCnt_q == 4'h8 ? lockCnt_q : lockCnt_q + 4'h1);
        end
    end
    assign pllLock = lockCnt_q == 4'h8;
    // switch conducts only while the pin is actively pulled low
    assign switchOn = !supplySwitchOe_n && !supplySwitchOut;
endmodule

// [tb/tb.sv]
// self-checking bench for the dual supply mode manager
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, regWrite, regRead, swResetReq, mediaRailPresent, cableIrq, wakeReq, supplySwitchOut;
    logic supplySwitchOe_n, ioHighZ, mediaIoTieLow, regulatorOn, coreReset_n, usbModeActive, switchOn;
    logic busAboveRise, busAboveFall, pllLock;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, rd;
    logic [1:0] regulatorLevelSel, railLevel;
    dsmm_pkg::dsmm_clkcfg_t clkCfg;
    int nMismatch = 0;
    int samplesChecked = 0;
    dsmm_mode_manager u_dsmm_mode_manager (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .busAboveRise(busAboveRise),
        .busAboveFall(busAboveFall), .pllLock(pllLock), .swResetReq(swResetReq), .mediaRailPresent(mediaRailPresent),
        .cableIrq(cableIrq), .wakeReq(wakeReq), .supplySwitchOut(supplySwitchOut), .supplySwitchOe_n(supplySwitchOe_n),
        .clkCfg(clkCfg), .ioHighZ(ioHighZ), .mediaIoTieLow(mediaIoTieLow), .regulatorOn(regulatorOn),
        .regulatorLevelSel(regulatorLevelSel), .coreReset_n(coreReset_n), .usbModeActive(usbModeActive));
    dsmm_supply_model u_dsmm_supply_model (.clk(clk), .rst_n(rst_n), .railLevel(railLevel), .pllOn(clkCfg.pllOn),
        .supplySwitchOut(supplySwitchOut), .supplySwitchOe_n(supplySwitchOe_n), .busAboveRise(busAboveRise),
        .busAboveFall(busAboveFall), .pllLock(pllLock), .switchOn(switchOn));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("FAIL %s expected %h got %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_run();
        for (int i = 0; i < 2000 && coreReset_n !== 1'b1; i++) @(posedge clk);
        settle(2);
        check("core run", 8'h01, 8'(coreReset_n));
    endtask
    task automatic expect_irq();
        logic seen;
        logic wake;
        seen = 1'b0;
        wake = 1'b0;
        for (int i = 0; i < 4; i++) begin
            settle(1);
            seen = seen | cableIrq;
            wake = wake | wakeReq;
        end
        check("cable irq", 8'h01, 8'(seen));
        check("wake req", 8'h01, 8'(wake));
    endtask
    task automatic check_mode(input logic usb);
        check("usb mode", 8'(usb), 8'(usbModeActive));
        check("pll on", 8'(usb), 8'(clkCfg.pllOn));
        check("pll sel", 8'(usb), 8'(clkCfg.pllClkSel));
        check("usb if", 8'(usb), 8'(clkCfg.usbIfOn));
        check("core max", usb ? 8'h08 : 8'h06, 8'(clkCfg.coreMaxMhz));
        check("coproc", usb ? 8'h18 : 8'h06, 8'(clkCfg.coprocMhz));
        check("switch oe_n", 8'(!usb), 8'(supplySwitchOe_n));
        check("switch on", 8'(usb), 8'(switchOn));
        check("ports hi-z", 8'h00, 8'(ioHighZ));
    endtask
    task automatic sw_reset(input logic usb);
        @(posedge clk);
        swResetReq <= 1'b1;
        @(posedge clk);
        swResetReq <= 1'b0;
        settle(1);
        check("ports hi-z", 8'h01, 8'(ioHighZ));
        check("core held", 8'h00, 8'(coreReset_n));
        check("switch oe_n", 8'(!usb), 8'(supplySwitchOe_n));
        check("pll on", 8'(usb), 8'(clkCfg.pllOn));
    endtask
    task automatic printVerdict();
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #120000;
        nMismatch++;
        printVerdict();
    end
    initial begin
        rst_n = 1'b0;
        {regAddr, regWdata, regWrite, regRead, swResetReq, railLevel} = '0;
        mediaRailPresent = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_run();
        check_mode(1'b0);
        reg_rd(dsmm_pkg::STATUS_OFS, rd);
        check("status sa", 8'h08, rd);
        reg_rd(dsmm_pkg::PCR_OFS, rd);
        check("ctl reset", 8'h00, rd);
        reg_rd(4'hf, rd);
        check("unmapped", 8'h00, rd);
        for (int i = 0; i < 4; i++) begin
            reg_wr(dsmm_pkg::PCR_OFS, 8'(i * 4 + 1));
            reg_rd(dsmm_pkg::PCR_OFS, rd);
            check("ctl rd", 8'(i * 4 + 1), rd);
            settle(1);
            check("level", 8'(i), 8'(regulatorLevelSel));
            check("reg on", 8'h01, 8'(regulatorOn));
        end
        reg_wr(dsmm_pkg::PCR_OFS, 8'h10);
        settle(2);
        check("reg on", 8'h00, 8'(regulatorOn));
        railLevel <= 2'h2;
        expect_irq();
        reg_rd(dsmm_pkg::PCR_OFS, rd);
        check("ctl plugged", 8'hf0, rd);
        check("still sa", 8'h00, 8'(usbModeActive));
        sw_reset(1'b1);
        wait_run();
        check_mode(1'b1);
        reg_rd(dsmm_pkg::STATUS_OFS, rd);
        check("status usb", 8'h0d, rd);
        mediaRailPresent <= 1'b0;
        settle(3);
        check("media tie", 8'h01, 8'(mediaIoTieLow));
        mediaRailPresent <= 1'b1;
        settle(3);
        check("media free", 8'h00, 8'(mediaIoTieLow));
        reg_wr(dsmm_pkg::PCR_OFS, 8'h00);
        railLevel <= 2'h0;
        expect_irq();
        sw_reset(1'b0);
        wait_run();
        check_mode(1'b0);
        printVerdict();
    end
endmodule
bind dsmm_mode_manager dsmm_mode_monitor u_dsmm_mode_monitor (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .busAboveRise(busAboveRise), .busAboveFall(busAboveFall),
    .swResetReq(swResetReq), .mediaRailPresent(mediaRailPresent), .cableIrq(cableIrq), .wakeReq(wakeReq),
    .supplySwitchOut(supplySwitchOut), .supplySwitchOe_n(supplySwitchOe_n), .clkCfg(clkCfg), .ioHighZ(ioHighZ),
    .mediaIoTieLow(mediaIoTieLow), .regulatorOn(regulatorOn), .regulatorLevelSel(regulatorLevelSel),
    .coreReset_n(coreReset_n), .usbModeActive(usbModeActive));
